// file: rtl/bstg_pkg.sv
// Constants and carrier types for the board status and tick generator block.
// Assumes a single 200 MHz clock and a plain strobe register port.
package bstg_pkg;

  localparam int unsigned BSTG_ADDR_W = 32;
  localparam int unsigned BSTG_DATA_W = 16;

  // Register byte addresses.
  localparam logic [31:0] BSTG_ADDR_SUPPLY = 32'h0f00_0000;
  localparam logic [31:0] BSTG_ADDR_PERIOD = 32'h0f40_0000;
  localparam logic [31:0] BSTG_ADDR_DS_RESET = 32'hf080_0000;
  localparam logic [31:0] BSTG_ADDR_DS_ANALYSE = 32'hf100_0000;
  localparam logic [31:0] BSTG_ADDR_DS_ERROR = 32'hf180_0000;
  localparam logic [31:0] BSTG_ADDR_TICK_DISABLE = 32'hf480_0000;
  localparam logic [31:0] BSTG_ADDR_IRQ_STATUS = 32'hf4c0_0000;
  localparam logic [31:0] BSTG_ADDR_IRQ_CLEAR = 32'hf4c0_0004;
  localparam logic [31:0] BSTG_ADDR_IRQ_ENABLE = 32'hf4c0_0008;

  // Field layout.
  localparam int unsigned BSTG_PERIOD_W = 6;
  localparam int unsigned BSTG_COUNT_W = 10;
  localparam int unsigned BSTG_PRESENCE_LSB = 8;
  localparam int unsigned BSTG_PRESENCE_W = 8;
  localparam logic [3:0] BSTG_PERIOD_LOW_BITS = 4'h0;

  // Reset values.
  localparam logic BSTG_RST_SUPPLY = 1'b0;
  localparam logic BSTG_RST_DS_RESET = 1'b0;
  localparam logic BSTG_RST_DS_ANALYSE = 1'b0;
  localparam logic BSTG_RST_TICK_DISABLE = 1'b1;
  localparam logic [5:0] BSTG_RST_PERIOD = 6'h00;
  localparam logic [15:0] BSTG_ZERO16 = 16'h0000;

  // Interrupt event bits: bit 0 tick, bit 1 downstream error rising.
  localparam int unsigned BSTG_NUM_EVT = 2;
  localparam int unsigned BSTG_EVT_TICK = 0;
  localparam int unsigned BSTG_EVT_DS_ERR = 1;

  // Counting clock: 5 MHz derived from the 200 MHz system clock.
  localparam int unsigned BSTG_CLK_HZ = 200_000_000;
  localparam int unsigned BSTG_TICK_HZ = 5_000_000;
  localparam int unsigned BSTG_TICK_DIV = BSTG_CLK_HZ / BSTG_TICK_HZ;
  localparam int unsigned BSTG_DIV_W = 6;

  // Connector pins, all active low at the pin.
  typedef struct packed {
    logic reset_n;
    logic analyse_n;
  } bstg_conn_out_s;

  typedef struct packed {
    logic error_n;
  } bstg_conn_in_s;

endpackage

// file: rtl/bstg_top.sv
// Board status registers, downstream reset/analyse/error control and periodic tick interrupt.
// Assumes all pin inputs are asynchronous to clk and the register port is clk-synchronous.
//
// Summary of operation
// - Every read returns module presence codes on bits 15:8, module 0 low.
// - An empty socket reads as all ones through pin pull-ups.
// - Presence codes are readable at any time, needing no configuration.
// - Downstream reset, analyse, error serve rear and front connectors together.
// - Writing 1 to downstream reset asserts reset on both connectors.
// - Downstream error reads the OR of rear and front error inputs.
// - Register bits active high, connector pins active low.
// - Tick generator uses a period register and a disable register.
// - Tick counter is ten bits, loaded from the programmed period.
// - Reload is period bits shifted up four, low nibble zero.
// - While enabled the counter decrements once per counting tick to zero.
// - Counting runs at 5 MHz, separate from the register bus rate.
// - At zero the periodic interrupt line is asserted.
// - Next counting tick reloads the counter and clears the interrupt line.
//
// The plain strobed port was chosen for this implementation.
module bstg_top
  import bstg_pkg::*;
#(
  parameter int unsigned TICK_DIV = BSTG_TICK_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [BSTG_ADDR_W-1:0] reg_addr,
  input wire logic [BSTG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [BSTG_DATA_W-1:0] reg_rdata,
  input wire logic [3:0] module_presence_code_0,
  input wire logic [3:0] module_presence_code_1,
  output bstg_conn_out_s rear_connector_out,
  output bstg_conn_out_s front_connector_out,
  input wire bstg_conn_in_s rear_connector_in,
  input wire bstg_conn_in_s front_connector_in,
  output logic supply_control,
  output logic periodic_interrupt_line,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: two stages, the first read only by the second.
  //
  // The presence pins and the error pins come from the board and from a
  // cable, so they can move at any time relative to clk.
  // Each pin passes two flip-flops before any decode logic sees it.
  // The cost is two cycles of latency, which no register read can notice
  // because software reads are far slower than the pins can settle.
  // The presence codes are static in practice, so no attempt is made to
  // keep the eight bits coherent with each other while they change.
  // A word read while a module is being fitted may mix old and new bits.
  // The error pins are sampled separately and only combined after the
  // second stage, so a glitch on one connector cannot race the other.

  logic [BSTG_PRESENCE_W-1:0] pd_meta;
  logic [BSTG_PRESENCE_W-1:0] pd_sync;
  logic [1:0] err_meta;
  logic [1:0] err_sync;
  logic [BSTG_PRESENCE_W-1:0] next_pd_meta;
  logic [BSTG_PRESENCE_W-1:0] next_pd_sync;
  logic [1:0] next_err_meta;
  logic [1:0] next_err_sync;

  always_comb begin
    next_pd_meta = {module_presence_code_1, module_presence_code_0};
    next_pd_sync = pd_meta;
    next_err_meta = {front_connector_in.error_n, rear_connector_in.error_n};
    next_err_sync = err_meta;
  end

  // Presence codes reset to all ones so an empty socket never reads zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pd_meta <= 8'hff;
      pd_sync <= 8'hff;
      err_meta <= 2'h3;
      err_sync <= 2'h3;
    end else begin
      pd_meta <= next_pd_meta;
      pd_sync <= next_pd_sync;
      err_meta <= next_err_meta;
      err_sync <= next_err_sync;
    end
  end

  logic ds_error;
  assign ds_error = ~err_sync[0] | ~err_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  //
  // All registers sit on one clk and are written by a single-cycle strobe.
  // Addresses are decoded in full, so a near miss is simply ignored.
  // The single-bit control registers use bit 0 only; the rest of a write
  // word is dropped without complaint.
  // Reads are registered: the answer appears in the cycle after the read
  // strobe and the port returns zero in every other cycle.
  // The upper byte of every read carries the presence codes, including
  // reads of write-only and unmapped addresses, so software can size its
  // memory before it has set anything else up.
  // The interrupt status bits are sticky. A clear written in the same
  // cycle as a new event loses, so no event can slip through unseen.
  // The downstream error read is live rather than sticky: a fault that
  // has gone away reads as zero, and only the status register remembers.

  logic supply_bit;
  logic ds_reset_bit;
  logic ds_analyse_bit;
  logic tick_disable;
  logic [BSTG_PERIOD_W-1:0] tick_period;
  logic [BSTG_NUM_EVT-1:0] irq_status;
  logic [BSTG_NUM_EVT-1:0] irq_enable;
  logic [BSTG_DATA_W-1:0] rdata;
  logic next_supply_bit;
  logic next_ds_reset_bit;
  logic next_ds_analyse_bit;
  logic next_tick_disable;
  logic [BSTG_PERIOD_W-1:0] next_tick_period;
  logic [BSTG_NUM_EVT-1:0] next_irq_status;
  logic [BSTG_NUM_EVT-1:0] next_irq_enable;
  logic [BSTG_DATA_W-1:0] next_rdata;
  logic [BSTG_NUM_EVT-1:0] evt;
  logic ds_error_d;
  logic tick_pulse;

  always_comb begin
    next_supply_bit = supply_bit;
    next_ds_reset_bit = ds_reset_bit;
    next_ds_analyse_bit = ds_analyse_bit;
    next_tick_disable = tick_disable;
    next_tick_period = tick_period;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (reg_wr) begin
      case (reg_addr)
        BSTG_ADDR_SUPPLY: next_supply_bit = reg_wdata[0];
        BSTG_ADDR_PERIOD: next_tick_period = reg_wdata[BSTG_PERIOD_W-1:0];
        BSTG_ADDR_DS_RESET: next_ds_reset_bit = reg_wdata[0];
        BSTG_ADDR_DS_ANALYSE: next_ds_analyse_bit = reg_wdata[0];
        BSTG_ADDR_TICK_DISABLE: next_tick_disable = reg_wdata[0];
        BSTG_ADDR_IRQ_CLEAR: next_irq_status = irq_status & ~reg_wdata[BSTG_NUM_EVT-1:0];
        BSTG_ADDR_IRQ_ENABLE: next_irq_enable = reg_wdata[BSTG_NUM_EVT-1:0];
        default: next_irq_status = irq_status;
      endcase
    end
    // A new event wins over a clear written in the same cycle.
    next_irq_status = next_irq_status | evt;

    // Each read carries the presence codes in the upper byte.
    next_rdata = {pd_sync, 8'h00};
    if (reg_rd) begin
      case (reg_addr)
        BSTG_ADDR_SUPPLY: next_rdata[0] = supply_bit;
        BSTG_ADDR_DS_RESET: next_rdata[0] = ds_reset_bit;
        BSTG_ADDR_DS_ANALYSE: next_rdata[0] = ds_analyse_bit;
        BSTG_ADDR_DS_ERROR: next_rdata[0] = ds_error;
        BSTG_ADDR_TICK_DISABLE: next_rdata[0] = tick_disable;
        BSTG_ADDR_IRQ_STATUS: next_rdata[BSTG_NUM_EVT-1:0] = irq_status;
        BSTG_ADDR_IRQ_ENABLE: next_rdata[BSTG_NUM_EVT-1:0] = irq_enable;
        default: next_rdata[0] = 1'b0;
      endcase
    end else begin
      next_rdata = BSTG_ZERO16;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_bit <= BSTG_RST_SUPPLY;
      ds_reset_bit <= BSTG_RST_DS_RESET;
      ds_analyse_bit <= BSTG_RST_DS_ANALYSE;
      tick_disable <= BSTG_RST_TICK_DISABLE;
      tick_period <= BSTG_RST_PERIOD;
      irq_status <= '0;
      irq_enable <= '0;
      rdata <= BSTG_ZERO16;
    end else begin
      supply_bit <= next_supply_bit;
      ds_reset_bit <= next_ds_reset_bit;
      ds_analyse_bit <= next_ds_analyse_bit;
      tick_disable <= next_tick_disable;
      tick_period <= next_tick_period;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting-rate enable: one pulse every TICK_DIV system clocks.
  //
  // The counting rate is made as an enable from clk rather than a second
  // clock, which keeps the whole block in one timing domain.
  // The trade-off is that the counting rate is an exact division of clk;
  // a free-running oscillator with its own drift is not modelled.
  // The divider runs from reset and never stops, so the phase of the
  // first counting pulse after an enable is not fixed.

  logic [BSTG_DIV_W-1:0] div_cnt;
  logic [BSTG_DIV_W-1:0] next_div_cnt;
  logic next_tick_pulse;

  always_comb begin
    if (div_cnt == BSTG_DIV_W'(TICK_DIV - 1)) begin
      next_div_cnt = '0;
      next_tick_pulse = 1'b1;
    end else begin
      next_div_cnt = div_cnt + 1'b1;
      next_tick_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt <= '0;
      tick_pulse <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick_pulse <= next_tick_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick counter. Period and disable are sampled only on the counting
  // pulse, so a register write mid-interval is taken at one clean edge.
  //
  // The machine has three states. Idle waits for the generator to be
  // switched on and then loads the counter. Count walks the value down
  // by one per counting pulse. Fire holds the interrupt line for one
  // counting period and then reloads for the next interval.
  // One interval is therefore the reload value plus two counting pulses.
  // A period write while counting is not seen until the next reload,
  // so a running interval is never cut short by software.
  // A period of zero gives the shortest legal interval of two pulses.
  // Switching the generator off always returns to idle, so switching it
  // back on starts a fresh interval from the programmed period.
  // The line is forced low when the generator is off, whatever the state,
  // so a stale pulse cannot linger after software has stopped it.

  typedef enum logic [1:0] {
    BSTG_ST_IDLE = 2'b00,
    BSTG_ST_COUNT = 2'b01,
    BSTG_ST_FIRE = 2'b10
  } bstg_tick_state_e;

  bstg_tick_state_e tick_state;
  bstg_tick_state_e next_tick_state;
  logic [BSTG_COUNT_W-1:0] tick_count;
  logic [BSTG_COUNT_W-1:0] next_tick_count;
  logic tick_line;
  logic next_tick_line;
  logic [BSTG_COUNT_W-1:0] reload_value;

  assign reload_value = {tick_period, BSTG_PERIOD_LOW_BITS};

  always_comb begin
    next_tick_state = tick_state;
    next_tick_count = tick_count;
    next_tick_line = tick_line;
    if (tick_pulse) begin
      if (tick_disable) begin
        next_tick_state = BSTG_ST_IDLE;
        next_tick_line = 1'b0;
      end else begin
        case (tick_state)
          BSTG_ST_IDLE: begin
            next_tick_count = reload_value;
            next_tick_state = BSTG_ST_COUNT;
          end
          BSTG_ST_COUNT: begin
            if (tick_count == '0) begin
              next_tick_line = 1'b1;
              next_tick_state = BSTG_ST_FIRE;
            end else begin
              next_tick_count = tick_count - 1'b1;
            end
          end
          BSTG_ST_FIRE: begin
            next_tick_count = reload_value;
            next_tick_line = 1'b0;
            next_tick_state = BSTG_ST_COUNT;
          end
          default: next_tick_state = BSTG_ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_state <= BSTG_ST_IDLE;
      tick_count <= '0;
      tick_line <= 1'b0;
    end else begin
      tick_state <= next_tick_state;
      tick_count <= next_tick_count;
      tick_line <= next_tick_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and registered outputs.
  //
  // Every output of the block comes straight from a flip-flop.
  // The outputs are built from the next-state values, so a write shows on
  // the pins at the same edge as it lands in its register.
  // The connector pins are active low; the inversion is done once here,
  // ahead of the output flops, so both connectors see the same value.
  // The tick event is taken from the rising edge of the line, and the
  // error event from the rising edge of the combined error.
  // The error edge detector resets to the idle level of the error, so
  // no false event follows the release of reset.

  always_comb begin
    evt = '0;
    evt[BSTG_EVT_TICK] = next_tick_line & ~tick_line;
    evt[BSTG_EVT_DS_ERR] = ds_error & ~ds_error_d;
  end

  bstg_conn_out_s next_conn;
  logic next_irq;

  always_comb begin
    next_conn.reset_n = ~next_ds_reset_bit;
    next_conn.analyse_n = ~next_ds_analyse_bit;
    next_irq = |(next_irq_status & next_irq_enable);
  end

  // Both connectors are fed from one value so they never differ.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rear_connector_out <= '1;
      front_connector_out <= '1;
      supply_control <= BSTG_RST_SUPPLY;
      periodic_interrupt_line <= 1'b0;
      irq <= 1'b0;
      ds_error_d <= 1'b0;
    end else begin
      rear_connector_out <= next_conn;
      front_connector_out <= next_conn;
      supply_control <= next_supply_bit;
      periodic_interrupt_line <= next_tick_line;
      irq <= next_irq;
      ds_error_d <= ds_error;
    end
  end

  // The read port is a plain copy of the read flop, so it stands for
  // exactly one cycle after each read and is zero otherwise.
  assign reg_rdata = rdata;

endmodule

// file: tb/bstg_far_model.sv
// Far-side downstream subsystem that reports faults on its error pins.
// Assumes the bench changes the fault lines just after a rising edge.
module bstg_far_model
  import bstg_pkg::*;
(
  input wire logic [1:0] fault,
  output bstg_conn_in_s rear_in,
  output bstg_conn_in_s front_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pins are active low, so a raised fault pulls its error line down.
  assign rear_in.error_n = !fault[0];
  assign front_in.error_n = !fault[1];
endmodule

// file: tb/bstg_top_sva.sv
// Port assertions for the board status and tick block.
// Assumes the bench holds pins steady around reads.
module bstg_top_sva
  import bstg_pkg::*;
#(
  parameter int unsigned TICK_DIV = BSTG_TICK_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [BSTG_ADDR_W-1:0] reg_addr,
  input wire logic [BSTG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [BSTG_DATA_W-1:0] reg_rdata,
  input wire logic [3:0] module_presence_code_0,
  input wire logic [3:0] module_presence_code_1,
  input wire bstg_conn_out_s rear_connector_out,
  input wire bstg_conn_out_s front_connector_out,
  input wire bstg_conn_in_s rear_connector_in,
  input wire bstg_conn_in_s front_connector_in,
  input wire logic periodic_interrupt_line
);
  localparam int DIS_MAX = TICK_DIV + 2;
  logic [2:0] up;
  logic [15:0] hi;
  // Synced pins are stale for a few cycles after reset, so reads wait on up.
  always_ff @(posedge clk) begin
    up <= sys_rst ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
    hi <= periodic_interrupt_line ? hi + 16'h0001 : 16'h0000;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_quiet;
    (up == 3'h7 && $stable({module_presence_code_1, module_presence_code_0,
      rear_connector_in, front_connector_in})) [*4];
  endsequence
  property p_wr_pin(logic [31:0] a, logic pin);
    reg_wr && reg_addr == a |=> pin == !$past(reg_wdata[0]);
  endproperty
  AST_PRESENCE: assert property (s_quiet ##0 reg_rd |=>
    reg_rdata[15:8] == {$past(module_presence_code_1), $past(module_presence_code_0)})
    else $error("presence code missing from read data");
  AST_ERR_OR: assert property (s_quiet ##0 reg_rd && reg_addr == BSTG_ADDR_DS_ERROR
    |=> reg_rdata[0] == !($past(rear_connector_in.error_n) && $past(front_connector_in.error_n)))
    else $error("error read is not the OR of both pins");
  AST_PINS_SAME: assert property (rear_connector_out == front_connector_out)
    else $error("rear and front connector outputs differ");
  AST_RESET_WR: assert property (p_wr_pin(BSTG_ADDR_DS_RESET,
    rear_connector_out.reset_n)) else $error("reset pin does not follow register write");
  AST_ANALYSE_WR: assert property (p_wr_pin(BSTG_ADDR_DS_ANALYSE,
    front_connector_out.analyse_n)) else $error("analyse pin does not follow register write");
  AST_RESET_HOLD: assert property (!(reg_wr && reg_addr == BSTG_ADDR_DS_RESET) |=>
    $stable(rear_connector_out.reset_n)) else $error("reset pin moved without a write");
  AST_TICK_WIDTH: assert property (hi <= TICK_DIV)
    else $error("tick line high longer than one counting period");
  AST_DISABLE: assert property (reg_wr && reg_addr == BSTG_ADDR_TICK_DISABLE
    && reg_wdata[0]
    |-> ##[1:DIS_MAX] !periodic_interrupt_line [*8]) else $error("tick line active while off");
endmodule
bind bstg_top bstg_top_sva #(.TICK_DIV(TICK_DIV)) u_sva (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .module_presence_code_0(module_presence_code_0),
  .module_presence_code_1(module_presence_code_1), .rear_connector_out(rear_connector_out),
  .front_connector_out(front_connector_out), .rear_connector_in(rear_connector_in),
  .front_connector_in(front_connector_in), .periodic_interrupt_line(periodic_interrupt_line));

// file: tb/bstg_test.sv
// Self-checking bench for the board status and tick block.
// Assumes a counting divider of 4 so one tick interval stays short.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module bstg_test
  import bstg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 4;
  typedef struct packed {
    logic [31:0] a; logic [15:0] w; logic [7:0] lo; logic [1:0] pins; logic sup;
  } bstg_row_s;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, supply, line, irq;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic [3:0] pd0 = 4'h6, pd1 = 4'hf;
  logic [1:0] fault = 2'h0;
  bstg_conn_out_s r_out, f_out;
  bstg_conn_in_s r_in, f_in;
  int failures = 0, n_tests = 0, k;
  bstg_row_s rows [8] = '{'{BSTG_ADDR_DS_RESET, 16'h0001, 8'h01, 2'b01, 1'b0},
    '{BSTG_ADDR_DS_ANALYSE, 16'h0001, 8'h01, 2'b00, 1'b0},
    '{BSTG_ADDR_DS_RESET, 16'hfffe, 8'h00, 2'b10, 1'b0},
    '{BSTG_ADDR_DS_ANALYSE, 16'h0000, 8'h00, 2'b11, 1'b0},
    '{BSTG_ADDR_SUPPLY, 16'h0001, 8'h01, 2'b11, 1'b1},
    '{BSTG_ADDR_PERIOD, 16'h0001, 8'h00, 2'b11, 1'b1},
    '{BSTG_ADDR_DS_ERROR, 16'hffff, 8'h00, 2'b11, 1'b1},
    '{32'h0000_1230, 16'hffff, 8'h00, 2'b11, 1'b1}};
  bstg_top #(.TICK_DIV(TD)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .module_presence_code_0(pd0), .module_presence_code_1(pd1), .rear_connector_out(r_out),
    .front_connector_out(f_out), .rear_connector_in(r_in), .front_connector_in(f_in),
    .supply_control(supply), .periodic_interrupt_line(line), .irq(irq));
  bstg_far_model u_far (.fault(fault), .rear_in(r_in), .front_in(f_in));
  ////////////////////////////////////////
  task automatic wr(input logic [31:0] a, input logic [15:0] w);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] q);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Every wait is bounded so a dead tick line ends the run instead of hanging.
  task automatic wait_line(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (line !== v && n < 2000);
    if (n >= 2000) begin
      failures++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK(d, {pd1, pd0, rows[i].lo})
      `CHK({r_out, f_out}, {rows[i].pins, rows[i].pins})
      `CHK(supply, rows[i].sup)
    end
    wr(BSTG_ADDR_IRQ_ENABLE, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      @(posedge clk) fault <= 2'(f);
      repeat (6) @(posedge clk);
      rd(BSTG_ADDR_DS_ERROR, d);
      `CHK(d, {pd1, pd0, 7'h00, 1'(f != 0)})
    end
    rd(BSTG_ADDR_IRQ_STATUS, d);
    `CHK({d[7:0], irq}, 9'h004)
    wr(BSTG_ADDR_IRQ_ENABLE, 16'h0003);
    `CHK(irq, 1'b1)
    wr(BSTG_ADDR_IRQ_CLEAR, 16'h0002);
    `CHK(irq, 1'b0)
    wr(BSTG_ADDR_TICK_DISABLE, 16'h0000);
    wait_line(1'b1, k);
    wait_line(1'b0, k);
    `CHK(k, TD)
    wait_line(1'b1, k);
    `CHK(k, 17 * TD)
    `CHK(irq, 1'b1)
    wr(BSTG_ADDR_TICK_DISABLE, 16'h0001);
    wr(BSTG_ADDR_IRQ_CLEAR, 16'h0003);
    repeat (200) @(posedge clk);
    rd(BSTG_ADDR_IRQ_STATUS, d);
    `CHK({d[7:0], line, irq}, 10'h000)
    @(posedge clk) pd0 <= 4'h9;
    wr(BSTG_ADDR_DS_RESET, 16'h0001);
    rd(BSTG_ADDR_SUPPLY, d);
    `CHK(d, {pd1, 4'h9, 8'h01})
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(BSTG_ADDR_TICK_DISABLE, d);
    `CHK({d[7:0], r_out, supply, line}, 12'h01c)
    test_done();
  end
endmodule
